// [hdl/sadc_defines.vh]
// Constants for the successive-approximation converter sequencer
// Assumes inclusion by the sequencer design file only; the divider and synchroniser do not include it
`ifndef SADC_DEFINES_VH
`define SADC_DEFINES_VH

// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define SADC_ADDR_W        2
`define SADC_ADDR_MODE     2'h0
`define SADC_ADDR_RESULT   2'h1
`define SADC_ADDR_CLKCTL   2'h2

// ---------------------------------------------------------------
// Mode register fields, reset values and result code
// ---------------------------------------------------------------
`define SADC_EN_BIT        7
`define SADC_CH_MSB        6
`define SADC_CH_LSB        4
`define SADC_START_BIT     3
`define SADC_DONE_BIT      2
`define SADC_MODE_RESET    8'h04
`define SADC_DONE_RESET    1'b1
`define SADC_RESULT_RESET  8'h7f
`define SADC_ALL_ONES      8'hff

// ---------------------------------------------------------------
// Clock control register fields
// ---------------------------------------------------------------
`define SADC_CK_STOP_BIT   3
`define SADC_CK_SRC_BIT    2
`define SADC_CK_PCC_MSB    1
`define SADC_CK_PCC_LSB    0

// ---------------------------------------------------------------
// Timing, in main oscillator periods
// ---------------------------------------------------------------
`define SADC_START_DLY     16
`define SADC_CONV_PERIODS  168
`define SADC_BIT_PERIODS   21

`endif

// [hdl/sadc_oscdiv.v]
// Main oscillator tick generator for the converter sequencer
// Assumes one system clock domain; tick is one cycle wide when DIV is above 1, and stays high every cycle when DIV is 1
`timescale 1ns/1ps
`default_nettype none
module sadc_oscdiv #(
  parameter DIV = 1
) (
  input  wire clk_sys_i,
  input  wire rst_n_i,
  input  wire run_i,
  output reg  tick_o
);
  reg [7:0] cnt_reg;

  // ---------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rst_n_i || !run_i) begin
      cnt_reg <= 8'h00;
      tick_o  <= 1'b0;
    end else if (cnt_reg == DIV - 1) begin
      cnt_reg <= 8'h00;
      tick_o  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      tick_o  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [hdl/sadc_sync.v]
// Two-stage synchroniser for a bus of pin-level inputs
// Assumes inputs asynchronous to the system clock
`timescale 1ns/1ps
`default_nettype none
module sadc_sync #(
  parameter W = 1
) (
  input  wire         clk_sys_i,
  input  wire         rst_n_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta_reg;

  // ---------------------------------------------------------------
  // Stages
  // ---------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta_reg <= {W{1'b0}};
      q_o      <= {W{1'b0}};
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// [hdl/sadc_seq.v]
// Sequencer of an eight-channel 8-bit successive-approximation converter
// Assumes an analog comparator outside; it reports compare and range flags
`timescale 1ns/1ps
`default_nettype none
`include "sadc_defines.vh"

module sadc_seq #(
  parameter OSC_DIV = 1
) (
  input  wire       clk_sys_i,
  input  wire       rst_n_i,
  input  wire [1:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire       cmp_above_i,
  input  wire       out_of_range_i,
  input  wire       standby_i,
  output reg  [2:0] chan_sel_o,
  output reg  [7:0] dac_code_o,
  output reg        sample_o,
  output reg        ref_enable_o,
  output reg        busy_o
);
  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam ST_IDLE  = 2'h0;
  localparam ST_DELAY = 2'h1;
  localparam ST_CONV  = 2'h2;

  reg  [1:0] state_reg;
  reg        en_reg;
  reg  [2:0] chan_reg;
  reg        start_reg;
  reg        done_reg;
  reg  [7:0] result_reg;
  reg  [3:0] clkctl_reg;
  reg  [7:0] sar_reg;
  reg  [7:0] trial_reg;
  reg  [7:0] per_reg;
  reg  [4:0] bitper_reg;
  reg        oor_reg;
  wire       osc_tick;
  wire [1:0] pin_sync;
  wire       cmp_s;
  wire       oor_s;
  wire       run;
  wire       mode_wr;
  wire       start_wr;

  // ---------------------------------------------------------------
  // Pin inputs
  // ---------------------------------------------------------------
  sadc_sync #(
    .W (2)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .d_i       ({cmp_above_i, out_of_range_i}),
    .q_o       (pin_sync)
  );
  assign cmp_s = pin_sync[1];
  assign oor_s = pin_sync[0];

  // Main clock only; clock stop bit or standby input freezes progress; source bit is ignored
  assign run = !clkctl_reg[`SADC_CK_STOP_BIT] && !standby_i;

  sadc_oscdiv #(
    .DIV (OSC_DIV)
  ) u_div (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .run_i     (run),
    .tick_o    (osc_tick)
  );

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  assign mode_wr  = wr_i && (addr_i == `SADC_ADDR_MODE);
  assign start_wr = mode_wr && wdata_i[`SADC_START_BIT];

  // ---------------------------------------------------------------
  // Registers and sequencer
  // ---------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      en_reg     <= 1'b0;
      chan_reg   <= 3'h0;
      start_reg  <= 1'b0;
      done_reg   <= `SADC_DONE_RESET;
      result_reg <= `SADC_RESULT_RESET;
      clkctl_reg <= 4'h0;
      state_reg  <= ST_IDLE;
      sar_reg    <= 8'h00;
      trial_reg  <= 8'h00;
      per_reg    <= 8'h00;
      bitper_reg <= 5'h00;
      oor_reg    <= 1'b0;
    end else begin
      if (wr_i && (addr_i == `SADC_ADDR_CLKCTL))
        clkctl_reg <= wdata_i[3:0];
      if (mode_wr) begin
        en_reg   <= wdata_i[`SADC_EN_BIT];
        chan_reg <= wdata_i[`SADC_CH_MSB:`SADC_CH_LSB];
      end
      if (start_wr) begin
        // A new start abandons any conversion in flight
        start_reg <= 1'b1;
        state_reg <= ST_DELAY;
        per_reg   <= 8'h00;
      end else if (run && osc_tick) begin
        case (state_reg)
          ST_IDLE: begin
            start_reg <= 1'b0;
          end
          ST_DELAY: begin
            if (per_reg == `SADC_START_DLY - 1) begin
              start_reg <= 1'b0;
              done_reg  <= 1'b0;
              per_reg   <= 8'h00;
              if (en_reg) begin
                state_reg  <= ST_CONV;
                sar_reg    <= 8'h00;
                trial_reg  <= 8'h80;
                bitper_reg <= 5'h00;
                oor_reg    <= 1'b0;
                result_reg <= 8'h00;
              end else begin
                result_reg <= `SADC_ALL_ONES;
                done_reg   <= 1'b1;
                state_reg  <= ST_IDLE;
              end
            end else begin
              per_reg <= per_reg + 8'h01;
            end
          end
          ST_CONV: begin
            per_reg <= per_reg + 8'h01;
            if (oor_s)
              oor_reg <= 1'b1;
            if (bitper_reg == `SADC_BIT_PERIODS - 1) begin
              bitper_reg <= 5'h00;
              // Keep the trial bit when input exceeds trial level
              if (cmp_s)
                sar_reg <= sar_reg | trial_reg;
              trial_reg <= trial_reg >> 1;
            end else begin
              bitper_reg <= bitper_reg + 5'h01;
            end
            if (per_reg == `SADC_CONV_PERIODS - 1) begin
              state_reg <= ST_IDLE;
              done_reg  <= 1'b1;
              if (oor_reg || oor_s)
                result_reg <= `SADC_ALL_ONES;
              else if (cmp_s && trial_reg != 8'h00)
                result_reg <= sar_reg | trial_reg;
              else
                result_reg <= sar_reg;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs and read port
  // ---------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_o      <= 8'h00;
      chan_sel_o   <= 3'h0;
      dac_code_o   <= 8'h00;
      sample_o     <= 1'b0;
      ref_enable_o <= 1'b0;
      busy_o       <= 1'b0;
    end else begin
      chan_sel_o   <= chan_reg;
      dac_code_o   <= sar_reg | trial_reg;
      sample_o     <= (state_reg == ST_CONV) && (per_reg == 8'h00);
      ref_enable_o <= en_reg;
      busy_o       <= (state_reg != ST_IDLE);
      if (rd_i && addr_i == `SADC_ADDR_MODE)
        rdata_o <= {en_reg, chan_reg, start_reg, done_reg, 2'h0};
      else if (rd_i && addr_i == `SADC_ADDR_RESULT)
        rdata_o <= result_reg;
      else if (rd_i && addr_i == `SADC_ADDR_CLKCTL)
        rdata_o <= {4'h0, clkctl_reg};
      else
        rdata_o <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// [verif/sadc_monitor.sv]
// Port checker for the converter sequencer
// Assumes a bind onto sadc_seq; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module sadc_monitor #(
  parameter OSC_DIV = 1
) (
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       standby_i,
  input wire logic [2:0] chan_sel_o,
  input wire logic [7:0] dac_code_o,
  input wire logic       sample_o,
  input wire logic       ref_enable_o,
  input wire logic       busy_o
);
  wire mw;
  assign mw = wr_i && addr_i == 2'h0;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  chk_chan_follow: assert property (
    mw ##1 !mw |=> chan_sel_o == $past(wdata_i[6:4], 2)) else $error("chan");
  chk_ref_follow: assert property (
    mw ##1 !mw |=> ref_enable_o == $past(wdata_i[7], 2)) else $error("ref");
  chk_busy_start: assert property (
    mw && wdata_i[3] && !standby_i |-> ##[1:2] busy_o) else $error("start");
  chk_no_start: assert property (
    !busy_o && !(mw && wdata_i[3]) && !$past(mw && wdata_i[3])
    |=> !busy_o) else $error("busy");
  chk_start_delay: assert property (
    mw && wdata_i[3] |=> !sample_o [*8]) else $error("early sample");
  chk_halt_freeze: assert property (
    standby_i && $past(standby_i) && busy_o && !wr_i
    |=> busy_o && $stable(dac_code_o))
    else $error("not frozen");
  chk_dac_idle: assert property (
    !busy_o && !$past(busy_o) |-> $stable(dac_code_o)) else $error("dac");
  chk_idle_read: assert property (
    rd_i && addr_i == 2'h0 && !busy_o && !$past(wr_i) && !$past(wr_i, 2)
    |=> rdata_o[3:0] == 4'h4) else $error("idle mode read");
  cover property ($fell(busy_o));
  cover property (standby_i && busy_o);
  cover property (mw && !wdata_i[7] && wdata_i[3]);
endmodule
`default_nettype wire

// [verif/sadc_analog_model.sv]
// Analog sources on eight channels and the comparator behind them
// Assumes the sequencer's channel select and trial code as inputs
`timescale 1ns/1ps
`default_nettype none
module sadc_analog_model #(parameter logic [63:0] LEVELS = 64'h0) (
  input  wire logic [2:0] chan_sel_i,
  input  wire logic [7:0] dac_code_i,
  output logic            cmp_above_o,
  output logic            out_of_range_o
);
  assign cmp_above_o = LEVELS[chan_sel_i * 8 +: 8] >= dac_code_i;
  assign out_of_range_o = chan_sel_i == 3'h5;
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the converter sequencer
// Assumes the sequencer, analog model and port checker compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [63:0] LVL = 64'h7f80_3ca5_015a_ff00;
  logic       clk_sys_i = 1'b0, rst_n_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0, rd_i = 1'b0, standby_i = 1'b0;
  logic       busy_o, sample_o, ref_enable_o, cmp_above_i, out_of_range_i;
  logic [7:0] rdata_o, dac_code_o;
  logic [2:0] chan_sel_o;
  int         num_errors = 0, check_count = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  sadc_seq #(.OSC_DIV(1)) sadc_seq_i (.*);
  sadc_analog_model #(.LEVELS(LVL)) sadc_analog_model_i (
    .chan_sel_i(chan_sel_o), .dac_code_i(dac_code_o),
    .cmp_above_o(cmp_above_i), .out_of_range_o(out_of_range_i));
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    d = rdata_o;
    @(posedge clk_sys_i);
  endtask
  task automatic chk_rd(input logic [1:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    check_count++;
    if (d !== e) begin
      num_errors++;
      $display("unexpected at %0t: read %h want %h", $time, d, e);
    end
  endtask
  // Start, optionally halt midway, poll done, then read the result
  task automatic conv(input logic [7:0] m, e, input int h);
    logic [7:0] d = 8'h00;
    int n = 0;
    wr_reg(2'h0, m | 8'h08);
    repeat (24) @(posedge clk_sys_i);
    standby_i <= h == 1;
    if (h == 2)
      wr_reg(2'h2, 8'h08);
    repeat (h * 200) @(posedge clk_sys_i);
    chk_rd(2'h0, m[7] ? m : 8'h04);
    standby_i <= 1'b0;
    wr_reg(2'h2, 8'h00);
    while (d[2] !== 1'b1 && n < 200) begin
      rd_reg(2'h0, d);
      n++;
    end
    chk_rd(2'h0, m | 8'h04);
    chk_rd(2'h1, e);
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    $display("unexpected at %0t: timeout", $time);
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    chk_rd(2'h0, 8'h04);
    wr_reg(2'h1, 8'h55);
    wr_reg(2'h3, 8'haa);
    chk_rd(2'h1, 8'h7f);
    chk_rd(2'h3, 8'h00);
    conv(8'h00, 8'hff, 0);
    for (int c = 0; c < 8; c++)
      conv({1'b1, c[2:0], 4'h0}, c == 5 ? 8'hff : LVL[c*8 +: 8], 0);
    wr_reg(2'h0, 8'hb8);
    repeat (60) @(posedge clk_sys_i);
    conv(8'hc0, 8'ha5, 0);
    conv(8'ha0, 8'h5a, 1);
    conv(8'ha0, 8'h5a, 2);
    wr_reg(2'h0, 8'h00);
    chk_rd(2'h0, 8'h04);
    print_verdict();
  end
endmodule
bind sadc_seq sadc_monitor #(.OSC_DIV(OSC_DIV)) sadc_monitor_i (.*);
`default_nettype wire
